// ===== src/scp_consts.svh
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// Word, frame and address sizes
`define SCP_WORD_BITS        16
`define SCP_FRAME_BITS       32
`define SCP_ADDR_BITS        11

// Instruction field positions and command values
`define SCP_CMD_BIT          15
`define SCP_CMD_WRITE        1'b1
`define SCP_CMD_READ         1'b0
`define SCP_MOD_SHIFT        6

// Bit counter values that close the instruction and the data word, and that mark the first data bit
`define SCP_CNT_INSTR_LAST   5'h0f
`define SCP_CNT_FIRST_DATA   5'h10
`define SCP_CNT_WORD_LAST    5'h1f

// Addresses of the shadowed divider words
`define SCP_PLL_INT_ADDR     11'h11e
`define SCP_PLL_FRAC_HI_ADDR 11'h11d
`define SCP_PLL_FRAC_LO_ADDR 11'h11c

// Reset values
`define SCP_PLL_INT_RESET    16'h0000
`define SCP_PLL_FRAC_RESET   32'h0000_0000
`define SCP_SYNC_RESET       4'h4

`endif

// ===== src/scp_pkg.sv
package scp_pkg;

   typedef enum logic [1:0] {
      SCP_PH_IDLE  = 2'b00,
      SCP_PH_INSTR = 2'b01,
      SCP_PH_DATA  = 2'b10
   } scp_phase_e;

   typedef struct packed {
      logic       cmd;
      logic [3:0] reserved;
      logic [4:0] module_sel;
      logic [5:0] reg_index;
   } scp_instr_s;

   typedef struct packed {
      logic [10:0] addr;
      logic [15:0] data;
   } scp_wr_s;

   function automatic logic [10:0] scp_global_addr(input scp_instr_s instr);
      scp_global_addr = {instr.module_sel, instr.reg_index};
   endfunction

endpackage

// ===== src/scp_sync.sv
module scp_sync #(
   parameter int         WIDTH     = 4,
   parameter logic [3:0] RESET_VAL = 4'h0
) (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stage1   <= RESET_VAL[WIDTH-1:0];
         sync_out <= RESET_VAL[WIDTH-1:0];
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// ===== src/scp_shadow.sv
`include "scp_consts.svh"

module scp_shadow #(
   parameter logic [10:0] INT_ADDR     = `SCP_PLL_INT_ADDR,
   parameter logic [10:0] FRAC_HI_ADDR = `SCP_PLL_FRAC_HI_ADDR,
   parameter logic [10:0] FRAC_LO_ADDR = `SCP_PLL_FRAC_LO_ADDR
) (
   input  wire logic            clk_sys,
   input  wire logic            reset_n,
   input  wire logic            wr_valid,
   input  wire scp_pkg::scp_wr_s wr,
   input  wire logic            select_rise,
   input  wire logic            ref_rise,
   output logic [15:0]          pll_integer_divider,
   output logic [31:0]          pll_fraction_divider
);

   logic [15:0] stage_int;
   logic [31:0] stage_frac;
   logic        pending;
   logic [15:0] next_stage_int;
   logic [31:0] next_stage_frac;
   logic        next_pending;
   logic [15:0] next_int;
   logic [31:0] next_frac;

   always_comb begin
      next_stage_int  = stage_int;
      next_stage_frac = stage_frac;
      next_pending    = pending;
      next_int        = pll_integer_divider;
      next_frac       = pll_fraction_divider;
      if (wr_valid) begin
         if (wr.addr == INT_ADDR)
            next_stage_int = wr.data;
         if (wr.addr == FRAC_HI_ADDR)
            next_stage_frac[31:16] = wr.data;
         if (wr.addr == FRAC_LO_ADDR)
            next_stage_frac[15:0] = wr.data;
      end
      // Edge seen with the select rise is not "after" it, so wait for the next
      if (pending && ref_rise) begin
         next_int     = stage_int;
         next_frac    = stage_frac;
         next_pending = 1'b0;
      end
      if (select_rise)
         next_pending = 1'b1;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stage_int            <= `SCP_PLL_INT_RESET;
         stage_frac           <= `SCP_PLL_FRAC_RESET;
         pending              <= 1'b0;
         pll_integer_divider  <= `SCP_PLL_INT_RESET;
         pll_fraction_divider <= `SCP_PLL_FRAC_RESET;
      end else begin
         stage_int            <= next_stage_int;
         stage_frac           <= next_stage_frac;
         pending              <= next_pending;
         pll_integer_divider  <= next_int;
         pll_fraction_divider <= next_frac;
      end
   end

endmodule

// ===== src/scp_port.sv
`include "scp_consts.svh"

module scp_port #(
   parameter logic [10:0] PLL_INT_ADDR     = `SCP_PLL_INT_ADDR,
   parameter logic [10:0] PLL_FRAC_HI_ADDR = `SCP_PLL_FRAC_HI_ADDR,
   parameter logic [10:0] PLL_FRAC_LO_ADDR = `SCP_PLL_FRAC_LO_ADDR
) (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic             three_wire_mode,
   input  wire logic             serial_clk,
   input  wire logic             serial_select_n,
   input  wire logic             serial_data_in,
   output logic                  serial_data_drv,
   output logic                  serial_data_oe_n,
   output logic                  serial_data_out,
   input  wire logic             ref_clk,
   output logic                  wr_valid,
   output scp_pkg::scp_wr_s      wr,
   output logic [10:0]           rd_addr,
   input  wire logic [15:0]      rd_data,
   output logic                  frame_active,
   output logic                  reserved_error,
   output logic [15:0]           pll_integer_divider,
   output logic [31:0]           pll_fraction_divider
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and edge detection

   logic [3:0] pins_sync;
   logic       s_sclk;
   logic       s_sen_n;
   logic       s_sdio;
   logic       s_ref;
   logic       sclk_q;
   logic       sen_q;
   logic       ref_q;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       select_rise;
   logic       ref_rise;

   // The serial clock is oversampled, so it must run well below clk_sys / 4
   scp_sync #(
      .WIDTH     (4),
      .RESET_VAL (`SCP_SYNC_RESET)
   ) u_sync (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .async_in ({ref_clk, serial_select_n, serial_data_in, serial_clk}),
      .sync_out (pins_sync)
   );

   assign s_sclk  = pins_sync[0];
   assign s_sdio  = pins_sync[1];
   assign s_sen_n = pins_sync[2];
   assign s_ref   = pins_sync[3];

   assign sclk_rise   = s_sclk & ~sclk_q;
   assign sclk_fall   = ~s_sclk & sclk_q;
   assign select_rise = s_sen_n & ~sen_q;
   assign ref_rise    = s_ref & ~ref_q;

   logic next_sclk_q;
   logic next_sen_q;
   logic next_ref_q;

   // Previous samples reset to each pin's idle level, so no false edge follows reset
   always_comb begin
      next_sclk_q = s_sclk;
      next_sen_q  = s_sen_n;
      next_ref_q  = s_ref;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sclk_q <= 1'b0;
         sen_q  <= 1'b1;
         ref_q  <= 1'b0;
      end else begin
         sclk_q <= next_sclk_q;
         sen_q  <= next_sen_q;
         ref_q  <= next_ref_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bit counter and instruction capture

   scp_pkg::scp_phase_e phase;
   scp_pkg::scp_phase_e next_phase;
   scp_pkg::scp_instr_s instr;
   scp_pkg::scp_instr_s next_instr;
   scp_pkg::scp_instr_s new_instr;
   logic [4:0]          cnt;
   logic [4:0]          next_cnt;
   logic [15:0]         shin;
   logic [15:0]         next_shin;
   logic [15:0]         shifted;
   logic                bit_taken;
   logic                instr_done;
   logic                word_done;

   // Read decode is needed by three groups, so it lives in one place
   function automatic logic instr_is_read(input scp_pkg::scp_instr_s word);
      instr_is_read = (word.cmd == `SCP_CMD_READ);
   endfunction

   assign shifted    = {shin[14:0], s_sdio};
   assign new_instr  = scp_pkg::scp_instr_s'(shifted);
   assign bit_taken  = ~s_sen_n & sclk_rise;
   assign instr_done = bit_taken & (cnt == `SCP_CNT_INSTR_LAST);
   assign word_done  = bit_taken & (cnt == `SCP_CNT_WORD_LAST);

   always_comb begin
      next_phase = phase;
      next_instr = instr;
      next_cnt   = cnt;
      next_shin  = shin;
      if (s_sen_n) begin
         // A partial word is dropped when select rises early
         next_phase = scp_pkg::SCP_PH_IDLE;
         next_cnt   = 5'h00;
      end else if (sclk_rise) begin
         next_shin = shifted;
         next_cnt  = cnt + 5'h01;
         if (instr_done)
            next_instr = new_instr;
         unique case (phase)
            scp_pkg::SCP_PH_IDLE: begin
               next_phase = scp_pkg::SCP_PH_INSTR;
            end
            scp_pkg::SCP_PH_INSTR: begin
               if (instr_done)
                  next_phase = scp_pkg::SCP_PH_DATA;
            end
            scp_pkg::SCP_PH_DATA: begin
               // Counter wraps, so the next word starts cleanly
               if (word_done)
                  next_phase = scp_pkg::SCP_PH_INSTR;
            end
            default: begin
               next_phase = scp_pkg::SCP_PH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         phase <= scp_pkg::SCP_PH_IDLE;
         instr <= '0;
         cnt   <= 5'h00;
         shin  <= 16'h0000;
      end else begin
         phase <= next_phase;
         instr <= next_instr;
         cnt   <= next_cnt;
         shin  <= next_shin;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read address and reserved-bit flag

   logic                load_pend;
   logic                next_load_pend;
   logic [10:0]         next_rd_addr;
   logic                next_reserved_error;

   always_comb begin
      next_load_pend      = 1'b0;
      next_rd_addr        = rd_addr;
      next_reserved_error = 1'b0;
      if (instr_done) begin
         // Only flagged: the word is still carried out
         next_reserved_error = |new_instr.reserved;
         if (instr_is_read(new_instr)) begin
            next_rd_addr   = scp_pkg::scp_global_addr(new_instr);
            next_load_pend = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         load_pend      <= 1'b0;
         rd_addr        <= 11'h000;
         reserved_error <= 1'b0;
      end else begin
         load_pend      <= next_load_pend;
         rd_addr        <= next_rd_addr;
         reserved_error <= next_reserved_error;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Completed write word

   scp_pkg::scp_wr_s    next_wr;
   logic                next_wr_valid;

   always_comb begin
      next_wr_valid = 1'b0;
      next_wr       = wr;
      if (word_done && !instr_is_read(instr)) begin
         next_wr_valid = 1'b1;
         next_wr.addr  = scp_pkg::scp_global_addr(instr);
         next_wr.data  = shifted;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_valid <= 1'b0;
         wr       <= '0;
      end else begin
         wr_valid <= next_wr_valid;
         wr       <= next_wr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data shifter and shared-pin drive

   logic [15:0]         shout;
   logic [15:0]         next_shout;
   logic                drive;
   logic                next_drive;
   logic                shift_out;

   // No shift on the fall just after loading, or bit 15 would never be seen
   assign shift_out = sclk_fall & ~s_sen_n & (phase == scp_pkg::SCP_PH_DATA) &
                      instr_is_read(instr) & (cnt != `SCP_CNT_FIRST_DATA);

   always_comb begin
      next_shout = shout;
      next_drive = drive;
      if (s_sen_n || word_done)
         next_drive = 1'b0;
      if (load_pend) begin
         // rd_addr loaded at the same edge as load_pend, so rd_data is valid now
         next_shout = rd_data;
         next_drive = three_wire_mode;
      end else if (shift_out) begin
         next_shout = {shout[14:0], 1'b0};
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         shout <= 16'h0000;
         drive <= 1'b0;
      end else begin
         shout <= next_shout;
         drive <= next_drive;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pins and shadowed dividers

   assign serial_data_drv  = shout[15];
   assign serial_data_oe_n = ~drive;
   // Held low in three-wire so the unused pin does not toggle
   assign serial_data_out  = shout[15] & ~three_wire_mode;
   assign frame_active     = ~s_sen_n;

   scp_shadow #(
      .INT_ADDR     (PLL_INT_ADDR),
      .FRAC_HI_ADDR (PLL_FRAC_HI_ADDR),
      .FRAC_LO_ADDR (PLL_FRAC_LO_ADDR)
   ) u_shadow (
      .clk_sys              (clk_sys),
      .reset_n              (reset_n),
      .wr_valid             (wr_valid),
      .wr                   (wr),
      .select_rise          (select_rise),
      .ref_rise             (ref_rise),
      .pll_integer_divider  (pll_integer_divider),
      .pll_fraction_divider (pll_fraction_divider)
   );

endmodule

// ===== test/scp_port_monitor.sv
module scp_port_monitor (
   input wire logic             clk_sys,
   input wire logic             reset_n,
   input wire logic             three_wire_mode,
   input wire logic             serial_clk,
   input wire logic             serial_select_n,
   input wire logic             serial_data_in,
   input wire logic             serial_data_drv,
   input wire logic             serial_data_oe_n,
   input wire logic             serial_data_out,
   input wire logic             ref_clk,
   input wire logic             wr_valid,
   input wire scp_pkg::scp_wr_s wr,
   input wire logic [10:0]      rd_addr,
   input wire logic [15:0]      rd_data,
   input wire logic             frame_active,
   input wire logic             reserved_error,
   input wire logic [15:0]      pll_integer_divider,
   input wire logic [31:0]      pll_fraction_divider
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////
   chk_oe_four_wire: assert property (!three_wire_mode |-> serial_data_oe_n)
      else $error("shared pin driven in four-wire mode");
   chk_out_three_zero: assert property (three_wire_mode |-> !serial_data_out)
      else $error("output pin not quiet in three-wire mode");
   chk_oe_in_frame: assert property (!serial_data_oe_n |-> frame_active)
      else $error("shared pin driven outside a frame");
   chk_oe_data_len: assert property ($fell(serial_data_oe_n) |-> !serial_data_oe_n[*8])
      else $error("shared pin released too early");
   // Shifts happen only after a fall, so a steady high clock must see steady data
   chk_rd_bit_hold: assert property (!serial_data_oe_n && $past(!serial_data_oe_n)
      && serial_clk && $past(serial_clk) |-> $stable(serial_data_drv))
      else $error("read bit moved while clock high");
   chk_wr_single: assert property (wr_valid |=> !wr_valid)
      else $error("write pulse longer than one cycle");
   chk_wr_framed: assert property (wr_valid |-> frame_active)
      else $error("write outside a frame");
   chk_res_pulse: assert property (reserved_error |=> !reserved_error)
      else $error("reserved flag longer than one cycle");
   chk_frame_start: assert property ($fell(serial_select_n) |-> ##[1:4] frame_active)
      else $error("frame not seen after select fell");
   chk_frame_end: assert property ($rose(serial_select_n) |-> ##[1:4] !frame_active)
      else $error("frame still seen after select rose");
   chk_shadow_idle: assert property ($changed(pll_integer_divider) |-> !frame_active)
      else $error("divider moved during a frame");
   chk_shadow_ref: assert property ($changed(pll_fraction_divider) |-> $past(ref_clk, 2))
      else $error("fraction moved without a reference edge");
   cover property (wr_valid);
   cover property ($fell(serial_data_oe_n));
   cover property (reserved_error);
   cover property ($changed(pll_integer_divider));
endmodule
bind scp_port scp_port_monitor u_scp_port_monitor (.clk_sys(clk_sys), .reset_n(reset_n),
   .three_wire_mode(three_wire_mode), .serial_clk(serial_clk),
   .serial_select_n(serial_select_n), .serial_data_in(serial_data_in),
   .serial_data_drv(serial_data_drv), .serial_data_oe_n(serial_data_oe_n),
   .serial_data_out(serial_data_out), .ref_clk(ref_clk), .wr_valid(wr_valid), .wr(wr),
   .rd_addr(rd_addr), .rd_data(rd_data), .frame_active(frame_active),
   .reserved_error(reserved_error), .pll_integer_divider(pll_integer_divider),
   .pll_fraction_divider(pll_fraction_divider));

// ===== test/scp_master_model.sv
module scp_master_model (
   input  wire logic clk_sys,
   input  wire logic three_wire_mode,
   input  wire logic serial_data_drv,
   input  wire logic serial_data_oe_n,
   input  wire logic serial_data_out,
   output logic      serial_clk,
   output logic      serial_select_n,
   output logic      serial_data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic own = 1'b1;
   logic mval = 1'b0;
   // A line nobody drives shows the inverse, so a stale copy cannot pass
   assign serial_data_in = !serial_data_oe_n ? serial_data_drv : (own ? mval : !mval);
   initial begin
      serial_clk = 1'b0;
      serial_select_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////////
   task automatic half;
      repeat (5) @(posedge clk_sys);
   endtask
   task automatic sel(input logic v);
      @(posedge clk_sys) serial_select_n <= v;
      half();
   endtask
   task automatic frame(input logic [31:0] w, input int n, output logic [15:0] r);
      r = 16'h0000;
      for (int i = 31; i >= 32 - n; i--) begin
         own <= !(three_wire_mode && !w[31] && i < 16);
         mval <= w[i];
         half();
         if (i < 16) r[i] = three_wire_mode ? serial_data_in : serial_data_out;
         serial_clk <= 1'b1;
         half();
         serial_clk <= 1'b0;
      end
   endtask
endmodule

// ===== test/tb_serial_config_port.sv
module tb_serial_config_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic             clk_sys;
   logic             reset_n;
   logic             three_wire_mode;
   logic             ref_clk;
   logic             sclk, sel_n, sdin, drv, oe_n, sdout, wr_valid, act, res_err;
   scp_pkg::scp_wr_s wr;
   logic [10:0]      rd_addr;
   logic [15:0]      rd_data, pll_int, r;
   logic [31:0]      pll_frac;
   int               mismatches = 0;
   int               check_count = 0;
   int               res_count = 0;
   scp_pkg::scp_wr_s wq[$];
   always #50 clk_sys = ~clk_sys;
   assign rd_data = {5'h00, rd_addr} ^ 16'h5a3c;
   always @(posedge clk_sys) begin
      if (wr_valid === 1'b1) wq.push_back(wr);
      if (res_err === 1'b1) res_count++;
   end
   scp_port u_scp_port (.clk_sys(clk_sys), .reset_n(reset_n),
      .three_wire_mode(three_wire_mode), .serial_clk(sclk), .serial_select_n(sel_n),
      .serial_data_in(sdin), .serial_data_drv(drv), .serial_data_oe_n(oe_n),
      .serial_data_out(sdout), .ref_clk(ref_clk), .wr_valid(wr_valid), .wr(wr),
      .rd_addr(rd_addr), .rd_data(rd_data), .frame_active(act), .reserved_error(res_err),
      .pll_integer_divider(pll_int), .pll_fraction_divider(pll_frac));
   scp_master_model u_scp_master_model (.clk_sys(clk_sys), .three_wire_mode(three_wire_mode),
      .serial_data_drv(drv), .serial_data_oe_n(oe_n), .serial_data_out(sdout),
      .serial_clk(sclk), .serial_select_n(sel_n), .serial_data_in(sdin));
   ////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic expect_wr(input logic [10:0] a, input logic [15:0] d);
      scp_pkg::scp_wr_s s;
      s = '0;
      if (wq.size() != 0) s = wq.pop_front();
      check("write word", {5'h00, a, d}, {5'h00, s});
   endtask
   task automatic wframe(input logic [10:0] a, input logic [15:0] d);
      u_scp_master_model.frame({5'h10, a, d}, 32, r);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_write_pair(input logic mode);
      @(posedge clk_sys) three_wire_mode <= mode;
      u_scp_master_model.sel(1'b0);
      wframe(11'h2c5, 16'hc3a5);
      wframe(11'h7ff, 16'h0001);
      u_scp_master_model.sel(1'b1);
      expect_wr(11'h2c5, 16'hc3a5);
      expect_wr(11'h7ff, 16'h0001);
   endtask
   task automatic t_read(input logic mode, input logic [10:0] a);
      @(posedge clk_sys) three_wire_mode <= mode;
      u_scp_master_model.sel(1'b0);
      u_scp_master_model.frame({5'h00, a, 16'h0000}, 32, r);
      check("read data", {16'h0000, {5'h00, a} ^ 16'h5a3c}, {16'h0000, r});
      check("read address", {21'h0, a}, {21'h0, rd_addr});
      wframe(11'h035, 16'h8001);
      u_scp_master_model.sel(1'b1);
      expect_wr(11'h035, 16'h8001);
   endtask
   task automatic t_reserved;
      int n;
      n = res_count;
      u_scp_master_model.sel(1'b0);
      u_scp_master_model.frame({5'h1a, 11'h001, 16'h7e7e}, 32, r);
      u_scp_master_model.sel(1'b1);
      check("reserved flags", n + 1, res_count);
      expect_wr(11'h001, 16'h7e7e);
   endtask
   task automatic t_cut;
      u_scp_master_model.sel(1'b0);
      u_scp_master_model.frame({5'h10, 11'h100, 16'hffff}, 20, r);
      u_scp_master_model.sel(1'b1);
      check("writes after cut frame", 0, wq.size());
   endtask
   task automatic t_shadow;
      u_scp_master_model.sel(1'b0);
      wframe(11'h11e, 16'h1234);
      wframe(11'h11d, 16'habcd);
      wframe(11'h11c, 16'h5678);
      u_scp_master_model.sel(1'b1);
      check("integer before ref", 0, {16'h0000, pll_int});
      check("fraction before ref", 0, pll_frac);
      wq.delete();
      @(posedge clk_sys) ref_clk <= 1'b1;
      repeat (5) @(posedge clk_sys);
      ref_clk <= 1'b0;
      repeat (5) @(posedge clk_sys);
      check("integer", 32'h0000_1234, {16'h0000, pll_int});
      check("fraction", 32'habcd_5678, pll_frac);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      three_wire_mode = 1'b0;
      ref_clk = 1'b0;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_write_pair(1'b0);
      t_write_pair(1'b1);
      t_read(1'b0, 11'h4d3);
      t_read(1'b1, 11'h12a);
      t_reserved();
      t_cut();
      t_shadow();
      tally_and_finish();
   end
   // Whole run is about 4150 cycles; this leaves ample room
   initial begin
      #3_000_000;
      mismatches++;
      tally_and_finish();
   end
endmodule
